// ---- include/pwtd_pkg.sv ----
// Package for the pulsewidth temperature decoder: constants and carriers
package pwtd_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 20000000;          // System clock rate
   localparam int unsigned TICK_HZ = 1000000;          // Phase count rate
   // Prescale divisor: value n-1 divides by n
   localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
   localparam logic [7:0] PRESCALE_RST = 8'(TICK_DIV - 1);

   // ----------------------------------------
   // Counter layout
   // ----------------------------------------
   localparam int unsigned CNT_W = 16;                 // Two cascaded 8-bit stages
   localparam int unsigned STAGE_W = 8;                // Width of each stage
   localparam logic [15:0] CNT_RST = 16'h0000;         // Counter after clear
   localparam logic [15:0] CNT_FULL = 16'hffff;        // Saturation and full scale
   localparam int unsigned ERR_BIT = 15;               // Set above 32 ms

   // ----------------------------------------
   // Temperature arithmetic, 14.2 fixed point
   // ----------------------------------------
   localparam logic [15:0] TEMP_OFS_Q2 = 16'h03ac;     // 235 times 4
   localparam logic [15:0] TEMP_GAIN = 16'h0190;       // 400
   localparam int unsigned QUO_W = 18;                 // Quotient width
   localparam int unsigned DIV_STEPS = 18;             // One bit per cycle

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   // One captured phase
   typedef struct packed {
      logic        level;     // Level of the phase that ended
      logic [15:0] time_us;   // Duration in counts
      logic        err;       // Counter top bit seen
   } pwtd_phase_t;

   // Finished result
   typedef struct packed {
      logic [15:0] temp_q2;   // Celsius, two fractional bits
      logic        err;       // Either phase out of range
   } pwtd_result_t;

   // Divider state
   typedef enum logic [1:0] {
      PWTD_IDLE = 2'b00,
      PWTD_MUL  = 2'b01,
      PWTD_DIV  = 2'b10,
      PWTD_DONE = 2'b11
   } pwtd_state_t;

endpackage

// ---- src/pwtd_hold.sv ----
// Holding register bank for captured phase durations
`timescale 1ns/1ns
module pwtd_hold
   import pwtd_pkg::*;
#(
   parameter int unsigned DUAL = 1    // 1: high and low held apart
)(
   input  wire logic clk_i,
   input  wire logic srst_i,
   input  wire logic wr_i,            // Capture strobe
   input  wire pwtd_phase_t phase_i,  // Captured phase
   output logic [15:0] high_phase_time_o,
   output logic [15:0] low_phase_time_o,
   output logic polarity_o,           // Level of last held phase
   output logic err_o
);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   if (DUAL > 1) begin : g_bad
      $error("pwtd_hold: DUAL must be 0 or 1");
   end

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   // With DUAL=1 each capture steered by level of the ended phase; with DUAL=0 both registers take it
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         high_phase_time_o <= CNT_RST;
         low_phase_time_o <= CNT_RST;
         polarity_o <= 1'b0;
         err_o <= 1'b0;
      end else if (wr_i) begin
         polarity_o <= phase_i.level;
         err_o <= phase_i.err;
         if (DUAL == 0) begin
            // Reader must fetch value and polarity before next edge
            high_phase_time_o <= phase_i.time_us;
            low_phase_time_o <= phase_i.time_us;
         end else if (phase_i.level) begin
            high_phase_time_o <= phase_i.time_us;
         end else begin
            low_phase_time_o <= phase_i.time_us;
         end
      end
   end

endmodule

// ---- src/pwtd_top.sv ----
// Host side decoder for a duty-cycle temperature sensor output
//
// Contract
// - Time phases with a 1 MHz tick
// - Sixteen-bit counter from two 8-bit stages
// - Strobe on every sensor output edge
// - Level steers capture to high or low
// - Clear counter after each capture
// - Counter top bit set means error
// - Both phase durations held together
// - Optional single register with polarity
// - Temperature is 235 minus 400 times ratio
// - Down counter: elapsed is ffff minus remainder (an up counter is used instead)
// - Prescale value n-1 divides by n
// - Timing starts only at a detected edge
`timescale 1ns/1ns
module pwtd_top
   import pwtd_pkg::*;
#(
   parameter int unsigned DUAL = 1,       // Two holding registers
   parameter logic [7:0] PRESCALE = PRESCALE_RST
)(
   input  wire logic clk_i,
   input  wire logic srst_i,
   input  wire logic flag_input_pin_i,   // Raw sensor output
   output logic [15:0] high_phase_time_o,
   output logic [15:0] low_phase_time_o,
   output logic polarity_o,              // Level of phase just held
   output logic phase_err_o,             // Last phase overran 32 ms
   output logic capture_o,               // Pulse: new phase held
   output logic [15:0] temp_q2_o,        // Celsius in 14.2
   output logic temp_err_o,              // Result from a bad phase
   output logic temp_valid_o             // Pulse: new temperature
);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   if (DUAL > 1) begin : g_bad_dual
      $error("pwtd_top: DUAL must be 0 or 1");
   end
   if (PRESCALE == 8'h00) begin : g_bad_pre
      $error("pwtd_top: PRESCALE must be at least 1");
   end

   // ----------------------------------------
   // Input synchroniser and edge strobe
   // ----------------------------------------
   logic sync1;      // First stage, read only by sync2
   logic sync2;      // Settled level
   logic lvl_prev;   // Previous settled level
   logic edge_seen;  // Any edge observed since reset
   logic strobe;     // One cycle per edge

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         lvl_prev <= 1'b0;
      end else begin
         sync1 <= flag_input_pin_i;
         sync2 <= sync1;
         lvl_prev <= sync2;
      end
   end

   assign strobe = sync2 ^ lvl_prev;

   // First edge arms capture; the partial first phase is discarded
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         edge_seen <= 1'b0;
      end else if (strobe) begin
         edge_seen <= 1'b1;
      end
   end

   // ----------------------------------------
   // Prescaler to 1 MHz tick
   // ----------------------------------------
   logic [7:0] pre_cnt;  // Counts down from PRESCALE
   logic tick;           // One cycle per microsecond

   always_ff @(posedge clk_i) begin
      if (srst_i || strobe || pre_cnt == 8'h00) begin
         // Realigned at each edge, so each phase starts on a full tick
         pre_cnt <= PRESCALE;
      end else begin
         pre_cnt <= pre_cnt - 8'h01;
      end
   end
   assign tick = (pre_cnt == 8'h00) && !strobe;

   // ----------------------------------------
   // Cascaded phase counter
   // ----------------------------------------
   logic [STAGE_W-1:0] cnt_lo;  // Low stage
   logic [STAGE_W-1:0] cnt_hi;  // High stage
   logic cnt_sat;               // Counter at full scale
   logic [15:0] cnt_val;

   assign cnt_val = {cnt_hi, cnt_lo};
   assign cnt_sat = (cnt_val == CNT_FULL);

   always_ff @(posedge clk_i) begin
      if (srst_i || strobe) begin
         cnt_lo <= CNT_RST[7:0];
         cnt_hi <= CNT_RST[15:8];
      end else if (tick && !cnt_sat) begin
         cnt_lo <= cnt_lo + 8'h01;
         if (cnt_lo == 8'hff) begin
            cnt_hi <= cnt_hi + 8'h01;
         end
      end
   end
   // Capture uses the old counter on the strobe cycle, so clear follows it.
   // An up counter is used; the down-counter form ffff minus rest is unneeded.

   // ----------------------------------------
   // Capture into holding registers
   // ----------------------------------------
   pwtd_phase_t cap;  // Phase going to the holding bank
   logic cap_wr;

   // ended phase is opposite of new level
   assign cap.level = lvl_prev;
   assign cap.time_us = cnt_val;
   assign cap.err = cnt_val[ERR_BIT];
   assign cap_wr = strobe && edge_seen;

   pwtd_hold #(
      .DUAL(DUAL)
   ) u_hold (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .wr_i(cap_wr),
      .phase_i(cap),
      .high_phase_time_o(high_phase_time_o),
      .low_phase_time_o(low_phase_time_o),
      .polarity_o(polarity_o),
      .err_o(phase_err_o)
   );

   // Capture pulse, aligned with held outputs
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         capture_o <= 1'b0;
      end else begin
         capture_o <= cap_wr;
      end
   end

   // ----------------------------------------
   // Temperature computation
   // ----------------------------------------
   pwtd_state_t state;
   logic got_high;            // High phase seen since last low capture
   logic [15:0] t_high;       // Operand copies, robust to DUAL=0
   logic [15:0] t_low;
   logic op_err;
   logic [31:0] rem;          // Division remainder
   logic [QUO_W-1:0] quo;     // 400*T1/T2 with two fraction bits
   logic [4:0] step;
   logic [32:0] trial;

   // Copy operands; a low phase closing after a high phase completes a period
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         got_high <= 1'b0;
         t_high <= CNT_RST;
         t_low <= CNT_RST;
         op_err <= 1'b0;
      end else if (cap_wr) begin
         if (cap.level) begin
            t_high <= cap.time_us;
            op_err <= cap.err;
            got_high <= 1'b1;
         end else begin
            t_low <= cap.time_us;
            op_err <= op_err | cap.err;
            got_high <= 1'b0;
         end
      end
   end

   // Restoring division, one quotient bit per cycle
   assign trial = {rem, 1'b0} - {1'b0, t_low, 16'h0000} ;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= PWTD_IDLE;
         rem <= 32'h0000_0000;
         quo <= '0;
         step <= 5'h00;
      end else begin
         case (state)
            PWTD_IDLE: begin
               // Ratio wait: period ends at the rising edge closing T2
               if (cap_wr && !cap.level && got_high) begin
                  state <= PWTD_MUL;
               end
            end
            PWTD_MUL: begin
               // form 400 times T1; the scale by 4 comes from the two extra quotient steps
               rem <= 32'(t_high) * 32'(TEMP_GAIN);
               quo <= '0;
               step <= 5'h00;
               state <= PWTD_DIV;
            end
            PWTD_DIV: begin
               // Zero divisor yields the inverted top 18 bits of rem, flagged below as error
               if (!trial[32]) begin
                  rem <= trial[31:0];
                  quo <= {quo[QUO_W-2:0], 1'b1};
               end else begin
                  rem <= {rem[30:0], 1'b0};
                  quo <= {quo[QUO_W-2:0], 1'b0};
               end
               if (step == 5'(DIV_STEPS - 1)) begin
                  state <= PWTD_DONE;
               end else begin
                  step <= step + 5'h01;
               end
            end
            PWTD_DONE: begin
               state <= PWTD_IDLE;
            end
            default: begin
               state <= PWTD_IDLE;
            end
         endcase
      end
   end
   // Quotient is q*2^16 scaled by 2^-16 each shift: result carries 2 fraction bits

   // ratio in range keeps 400*r under 16 bits
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         temp_q2_o <= 16'h0000;
         temp_err_o <= 1'b0;
         temp_valid_o <= 1'b0;
      end else begin
         temp_valid_o <= (state == PWTD_DONE);
         if (state == PWTD_DONE) begin
            temp_q2_o <= TEMP_OFS_Q2 - quo[15:0];
            temp_err_o <= op_err || (t_low == 16'h0000) || (quo[QUO_W-1:16] != 2'b00);
         end
      end
   end

endmodule

// ---- verif/pwtd_properties.sv ----
// Port-level checker for the pulsewidth temperature decoder
`timescale 1ns/1ns
module pwtd_properties
   import pwtd_pkg::*;
#(
   parameter int unsigned DUAL = 1,       // Two holding registers
   parameter logic [7:0] PRESCALE = PRESCALE_RST
)(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic flag_input_pin_i,
   input wire logic [15:0] high_phase_time_o,
   input wire logic [15:0] low_phase_time_o,
   input wire logic polarity_o,
   input wire logic phase_err_o,
   input wire logic capture_o,
   input wire logic [15:0] temp_q2_o,
   input wire logic temp_err_o,
   input wire logic temp_valid_o
);
   // ------------------------------
   // Edge tracking helpers
   // ------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic armed;        // First pin edge already seen
   logic [2:0] quiet;  // Cycles since a pin edge, stops at 7
   // First edge only arms, so captures are expected after it
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         armed <= 1'b0;
         quiet <= 3'h7;
      end else begin
         armed <= armed | $changed(flag_input_pin_i);
         quiet <= $changed(flag_input_pin_i) ? 3'h0 : (quiet == 3'h7 ? 3'h7 : quiet + 3'h1);
      end
   end
   // ------------------------------
   // Properties
   // ------------------------------
   a_capture_pulse: assert property (capture_o |=> !capture_o)
      else $error("capture pulse longer than one cycle");
   a_edge_capture: assert property (armed && $changed(flag_input_pin_i) |-> ##[2:6] capture_o)
      else $error("pin edge gave no capture");
   a_capture_cause: assert property (capture_o |-> quiet != 3'h7)
      else $error("capture without a recent pin edge");
   a_level_steer: assert property (capture_o |-> polarity_o == !flag_input_pin_i)
      else $error("held polarity does not match ended phase");
   a_held_stable: assert property (!capture_o |-> $stable(high_phase_time_o) && $stable(low_phase_time_o))
      else $error("held times moved without a capture");
   a_other_kept: assert property ((DUAL == 1) && capture_o |->
      (polarity_o ? $stable(low_phase_time_o) : $stable(high_phase_time_o)))
      else $error("capture disturbed the other phase register");
   a_err_flag: assert property (capture_o |->
      phase_err_o == (polarity_o ? high_phase_time_o[15] : low_phase_time_o[15]))
      else $error("phase error flag differs from count top bit");
   a_result_timing: assert property (capture_o && !polarity_o |-> ##[16:24] temp_valid_o)
      else $error("no temperature after low phase capture");
   a_temp_err: assert property (temp_valid_o && !temp_err_o |->
      !high_phase_time_o[15] && !low_phase_time_o[15])
      else $error("good result from an overrun phase");
   c_high_capture: cover property (capture_o && polarity_o);
   c_low_capture: cover property (capture_o && !polarity_o);
   c_bad_result: cover property (temp_valid_o && temp_err_o);
endmodule

// ---- verif/pwtd_sensor_model.sv ----
// Behavioural duty-cycle temperature sensor feeding the decoder pin
`timescale 1ns/1ns
module pwtd_sensor_model #(
   parameter int DIV = 2                 // Clocks per count tick
)(
   input wire logic clk_i,
   input wire logic en_i,                // Start periods when high
   input wire logic [31:0] hi_ticks_i,   // High phase in ticks
   input wire logic [31:0] lo_ticks_i,   // Low phase in ticks
   output logic pin_o,                   // Push-pull sensor output
   output int done_hi_o,                 // Length of last high phase
   output int done_lo_o                  // Length of last low phase
);
   int h;  // Lengths latched at period start
   int l;
   // Output idles low; lengths only change at a period start
   initial begin
      pin_o = 1'b0;
      done_hi_o = 1;
      done_lo_o = 1;
      forever begin
         @(posedge clk_i);
         if (en_i) begin
            h = int'(hi_ticks_i);
            l = int'(lo_ticks_i);
            pin_o <= 1'b1;
            repeat (h * DIV) @(posedge clk_i);
            pin_o <= 1'b0;
            done_hi_o <= h;
            repeat (l * DIV - 1) @(posedge clk_i);
            done_lo_o <= l;
         end
      end
   end
endmodule

// ---- verif/test_pulsewidth_temp_decoder.sv ----
// Self-checking bench for the pulsewidth temperature decoder
`timescale 1ns/1ns
module test_pulsewidth_temp_decoder;
   import pwtd_pkg::*;
   // ------------------------------
   // Signals
   // ------------------------------
   localparam logic [7:0] PRESC = 8'h01;  // Divide by two keeps runs short
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic sens_en = 1'b0;
   int hi_t = 100;
   int lo_t = 300;
   int base;  // Low phase length before the ratio is applied
   logic [15:0] single_hi;  // Single register variant outputs
   logic [15:0] single_lo;
   logic single_pol;
   logic single_cap;
   int done_hi;
   int done_lo;
   int err_count = 0;
   int tests_run = 0;
   logic flag_input_pin_i;
   logic [15:0] high_phase_time_o;
   logic [15:0] low_phase_time_o;
   logic [15:0] temp_q2_o;
   logic polarity_o;
   logic phase_err_o;
   logic capture_o;
   logic temp_err_o;
   logic temp_valid_o;
   initial forever #25 clk_i = ~clk_i;
   pwtd_sensor_model #(.DIV(2)) sens_u (.clk_i(clk_i), .en_i(sens_en), .hi_ticks_i(hi_t),
      .lo_ticks_i(lo_t), .pin_o(flag_input_pin_i), .done_hi_o(done_hi), .done_lo_o(done_lo));
   pwtd_top #(.DUAL(1), .PRESCALE(PRESC)) dut_u (.clk_i(clk_i), .srst_i(srst_i),
      .flag_input_pin_i(flag_input_pin_i), .high_phase_time_o(high_phase_time_o),
      .low_phase_time_o(low_phase_time_o), .polarity_o(polarity_o), .phase_err_o(phase_err_o),
      .capture_o(capture_o), .temp_q2_o(temp_q2_o), .temp_err_o(temp_err_o), .temp_valid_o(temp_valid_o));
   // Single holding register variant on the same pin
   pwtd_top #(.DUAL(0), .PRESCALE(PRESC)) dut_single_u (.clk_i(clk_i), .srst_i(srst_i),
      .flag_input_pin_i(flag_input_pin_i), .high_phase_time_o(single_hi), .low_phase_time_o(single_lo),
      .polarity_o(single_pol), .phase_err_o(), .capture_o(single_cap), .temp_q2_o(), .temp_err_o(),
      .temp_valid_o());
   // ------------------------------
   // Compare and report tasks
   // ------------------------------
   // Counts allow one tick of slack: edges land between ticks
   task automatic check_val(input string name, input int exp, input logic [15:0] got, input int tol);
      logic signed [15:0] d;
      d = got - 16'(exp);
      tests_run++;
      if ((^got === 1'bx) || d > tol || d < -tol) begin
         err_count++;
         $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
      end
   endtask
   task automatic check_flag(input string name, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %b, seen %b", name, exp, got);
      end
   endtask
   task automatic close_out();
      if (err_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Bounded wait for a number of finished results
   task automatic wait_results(input int n, input int lim);
      int seen;
      seen = 0;
      for (int k = 0; k < lim && seen < n; k++) begin
         @(posedge clk_i);
         if (temp_valid_o === 1'b1) seen++;
      end
      if (seen < n) begin
         err_count++;
         $display("unexpected result count: expected %0d, seen %0d", n, seen);
         close_out();
      end
   endtask
   // ------------------------------
   // Reference model at every capture and result
   // ------------------------------
   always @(posedge clk_i) begin
      if (!srst_i && capture_o === 1'b1) begin
         if (polarity_o === 1'b1) begin
            check_val("high_phase_time", done_hi, high_phase_time_o, 1);
            check_flag("phase_err", done_hi >= 32768, phase_err_o);
         end else begin
            check_val("low_phase_time", done_lo, low_phase_time_o, 1);
            check_flag("phase_err", done_lo >= 32768, phase_err_o);
         end
      end
      // Shared register: both outputs carry the phase that just ended
      if (!srst_i && single_cap === 1'b1) begin
         check_val("single_high_reg", flag_input_pin_i ? done_lo : done_hi, single_hi, 1);
         check_val("single_low_reg", flag_input_pin_i ? done_lo : done_hi, single_lo, 1);
         check_flag("single_polarity", !flag_input_pin_i, single_pol);
      end
      if (!srst_i && temp_valid_o === 1'b1) begin
         check_flag("temp_err", done_lo >= 32768, temp_err_o);
         if (done_lo < 32768) check_val("temp_q2", 940 - (1600 * done_hi) / done_lo, temp_q2_o, 12);
      end
   end
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      void'($urandom(38998));
      repeat (12) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check_val("reset_times", 0, high_phase_time_o | low_phase_time_o | temp_q2_o, 0);
      check_flag("reset_flags", 1'b0, capture_o | polarity_o | phase_err_o | temp_err_o | temp_valid_o);
      // Random periods, one overrun low phase mimics a broken wire
      for (int i = 0; i < 8; i++) begin
         base = 300 + int'($urandom % 201);
         hi_t <= base * (4 + int'($urandom % 3)) / 10;
         lo_t <= (i == 4) ? 33000 : base;
         sens_en <= 1'b1;
         // Values set here reach the next period; the overrun result lands at i == 5
         wait_results(1, (i == 5) ? 70000 : 4000);
      end
      close_out();
   end
endmodule
bind pwtd_top pwtd_properties #(.DUAL(DUAL), .PRESCALE(PRESCALE)) chk_u (.clk_i(clk_i), .srst_i(srst_i),
   .flag_input_pin_i(flag_input_pin_i), .high_phase_time_o(high_phase_time_o),
   .low_phase_time_o(low_phase_time_o), .polarity_o(polarity_o), .phase_err_o(phase_err_o),
   .capture_o(capture_o), .temp_q2_o(temp_q2_o), .temp_err_o(temp_err_o), .temp_valid_o(temp_valid_o));
